/* core/sensor_param_defs.svh */
// Index map, field positions and default values of the parameter handler
`ifndef SENSOR_PARAM_DEFS_SVH
`define SENSOR_PARAM_DEFS_SVH
`define IDX_SYS_CMD       16'h0002
`define IDX_LOCKS         16'h000C
`define IDX_CH1_PTS       16'h003C
`define IDX_CH2_CFG       16'h003F
`define IDX_PIN2          16'h0079
`define IDX_POS_OFS       16'h0101
`define IDX_DET_RANGE     16'h0104
`define IDX_TEMP          16'h1100
`define IDX_TEMP_CLR      16'h1101
`define IDX_OP_HOURS      16'h1104
`define IDX_PWR_CYC       16'h1105
`define IDX_LAST_TRAVEL   16'h1114
`define IDX_TOTAL_TRAVEL  16'h1116
`define IDX_CYCLE_SUM     16'h111E
`define IDX_DIAG_CLR      16'h112E
`define IDX_ALERTS        16'h1130
`define IDX_CH3_PTS       16'h4000
`define IDX_CH8_CFG       16'h400B
`define LOCK_UI_BIT       3
`define DIAG_CLR_TRAVEL   8'h01
`define DIAG_CLR_CYCLES   8'h02
`define MODE_SINGLE       8'h01
`define MODE_WINDOW       8'h02
`define MODE_TWO_POINT    8'h03
`define MODE_CYLINDER     8'h04
`define MODE_MOVE         8'h82
`define MODE_GRIP         8'h83
`define CFG_DEFAULT       32'h0046_0400
`define PIN2_OFF          8'h00
`define PIN2_QINT2        8'h01
`define TEACH_MIN_SEP     16'h0064
`define LEARN_STROKES     2'h2
`define DET_LOW           16'hF63C
`define DET_HIGH          16'h09C4
`define PD_SCALE          8'hFE
`define TEMP_LOWEST       16'h8000
`define TEMP_HIGHEST      16'h7FFF
`endif

/* core/sensor_param_pkg.sv */
// Types shared by the parameter handler and its users
package sensor_param_pkg;
  typedef enum logic [7:0] {
    CMD_TEACH_START = 8'h4B,
    CMD_TEACH_STOP  = 8'h4C,
    CMD_TEACH_STORE = 8'h4D,
    CMD_RESTART     = 8'h80,
    CMD_APP_RESET   = 8'h81,
    CMD_FACTORY     = 8'h82,
    CMD_RELEARN     = 8'hC0,
    CMD_DIAG_RESET  = 8'hE4,
    CMD_ALERT_CLEAR = 8'hE5
  } sys_cmd_t;
  typedef enum logic [1:0] {
    TEACH_IDLE = 2'b00,
    TEACH_RUN  = 2'b01,
    TEACH_DONE = 2'b10
  } teach_state_t;
  typedef struct packed {
    logic        write;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } req_t;
  typedef struct packed {
    logic        error;
    logic [31:0] data;
  } rsp_t;
  typedef struct packed {
    logic [15:0] pos;
    logic [7:0]  scale;
    logic [7:0]  bits;
  } pd_t;
endpackage

/* core/sensor_param_command_handler.sv */
// Parameter, system command and teach handler of the position sensor
`timescale 1ns/1ps
`default_nettype none
`include "sensor_param_defs.svh"
module sensor_param_command_handler (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   reqValid,
  input  wire sensor_param_pkg::req_t req,
  output logic                        rspValid,
  output var sensor_param_pkg::rsp_t  rsp,
  input  wire logic [15:0]            measPos,
  input  wire logic                   strokeEvt,
  input  wire logic [15:0]            strokeTravel,
  input  wire logic                   cycleEvt,
  input  wire logic                   stopEvt,
  input  wire logic [15:0]            stopPos,
  input  wire logic                   hourTick,
  input  wire logic                   powerUpEvt,
  input  wire logic [15:0]            tempNow,
  input  wire logic [15:0]            accelNow,
  input  wire logic [7:0]             alertIn,
  input  wire logic [7:0]             swIn,
  input  wire logic                   teachButtonPin,
  output logic                        teachPress,
  output logic                        pin2Out,
  output logic                        pin2Oe,
  output var sensor_param_pkg::pd_t   procData,
  output logic [15:0]                 mdcLow,
  output logic [15:0]                 mdcHigh,
  output logic                        learned,
  output logic                        identReset,
  output logic                        deviceRestart
);
  import sensor_param_pkg::*;

  function automatic logic [4:0] chanDecode(input logic [15:0] idx);
    logic [15:0] off;
    off = idx - `IDX_CH3_PTS;
    chanDecode = 5'h00;
    if (idx >= `IDX_CH1_PTS && idx <= `IDX_CH2_CFG)
      chanDecode = {1'b1, idx[0], 2'b00, idx[1]};
    else if (idx >= `IDX_CH3_PTS && idx <= `IDX_CH8_CFG)
      chanDecode = {1'b1, off[0], 3'(off[3:1] + 3'h2)};
  endfunction

  function automatic logic cmdKnown(input logic [7:0] c);
    case (c)
      CMD_TEACH_START, CMD_TEACH_STOP, CMD_TEACH_STORE, CMD_RESTART,
      CMD_APP_RESET, CMD_FACTORY, CMD_RELEARN, CMD_DIAG_RESET,
      CMD_ALERT_CLEAR: cmdKnown = 1'b1;
      default:         cmdKnown = 1'b0;
    endcase
  endfunction

  function automatic logic farApart(input logic [15:0] a,
                                    input logic [15:0] b);
    logic [15:0] d;
    d = ($signed(a) > $signed(b)) ? a - b : b - a;
    farApart = d >= `TEACH_MIN_SEP;
  endfunction

  function automatic logic [31:0] cfgMerge(input logic [31:0] old,
                                           input logic [7:0]  sub,
                                           input logic [31:0] d);
    case (sub)
      8'h01:   cfgMerge = {old[31:8], d[7:0]};
      8'h02:   cfgMerge = {old[31:16], d[7:0], old[7:0]};
      8'h03:   cfgMerge = {d[15:0], old[15:0]};
      default: cfgMerge = d;
    endcase
  endfunction

  logic [15:0]  accessLocks;
  logic [7:0]   pin2Cfg;
  logic [15:0]  posOffset;
  logic [31:0]  detRange;
  logic [31:0]  chPts [8];
  logic [31:0]  chCfg [8];
  logic         dynCh1;
  logic [31:0]  totalTravel;
  logic [31:0]  cycleCount;
  logic [31:0]  opHoursAll;
  logic [31:0]  opHoursSince;
  logic [31:0]  powerAll;
  logic [31:0]  powerSince;
  logic [15:0]  lastTravel;
  logic [15:0]  accelPeak;
  logic [15:0]  tempCur;
  logic [15:0]  tempAllMax;
  logic [15:0]  tempAllMin;
  logic [15:0]  tempRstMax;
  logic [15:0]  tempRstMin;
  logic [7:0]   alertFlags;
  logic [1:0]   learnCount;
  teach_state_t teachState;
  logic [1:0]   teachCount;
  logic [15:0]  teachStop [3];
  logic         btnMeta;
  logic         btnSync;
  logic         btnLast;
  logic [31:0]  rdData;
  logic         rdOk;

  wire       isWr = reqValid & req.write;
  wire       isRd = reqValid & ~req.write;
  wire [7:0] code = req.data[7:0];
  wire [4:0] chDec = chanDecode(req.index);
  wire       chHit = chDec[4];
  wire       chIsCfg = chDec[3];
  wire [2:0] chSel = chDec[2:0];
  wire [7:0] chMode = chCfg[chSel][15:8];
  wire       cmdTaken = isWr & (req.index == `IDX_SYS_CMD);
  wire       storeOk = (teachState == TEACH_DONE) & teachCount[1];
  // Store without a finished teach run is refused
  wire       cmdOk = cmdTaken & cmdKnown(code)
                     & ((code != CMD_TEACH_STORE) | storeOk);
  wire       cmdStart = cmdOk & (code == CMD_TEACH_START);
  wire       cmdStop = cmdOk & (code == CMD_TEACH_STOP);
  wire       cmdStore = cmdOk & (code == CMD_TEACH_STORE);
  wire       cmdRestart = cmdOk & (code == CMD_RESTART);
  wire       cmdFactory = cmdOk & (code == CMD_FACTORY);
  wire       cmdAppReset = cmdOk & (code == CMD_APP_RESET);
  wire       cmdRelearn = cmdOk & (code == CMD_RELEARN);
  wire       cmdDiagReset = cmdOk & (code == CMD_DIAG_RESET);
  wire       cmdAlertClr = cmdOk & (code == CMD_ALERT_CLEAR);
  wire       restore = cmdFactory | cmdAppReset;
  // Only window and two-point modes take points
  wire       modeManual2 = (chMode == `MODE_WINDOW)
                           | (chMode == `MODE_TWO_POINT);
  wire       wrPts = isWr & chHit & ~chIsCfg & modeManual2;
  // Mode of a dynamically taught channel is locked
  wire       modeLocked = dynCh1 & (chSel == 3'h0)
                          & ((req.sub == 8'h00) | (req.sub == 8'h02));
  wire       wrCfg = isWr & chHit & chIsCfg & ~modeLocked;
  wire       wrLocks = isWr & (req.index == `IDX_LOCKS);
  wire       wrPin2 = isWr & (req.index == `IDX_PIN2);
  wire       wrOfs = isWr & (req.index == `IDX_POS_OFS);
  wire       tempClr = isWr & (req.index == `IDX_TEMP_CLR);
  wire       diagHit = isWr & (req.index == `IDX_DIAG_CLR);
  wire       clrTravel = diagHit & (code == `DIAG_CLR_TRAVEL);
  wire       clrCycles = diagHit & (code == `DIAG_CLR_CYCLES);
  wire       wrOk = cmdOk | wrPts | wrCfg | wrLocks | wrPin2 | wrOfs
                    | tempClr | clrTravel | clrCycles;
  wire [15:0] posSum = measPos + posOffset;
  wire [1:0]  nextTeachCount = teachCount + 2'h1;
  wire        stopFar = (teachCount == 2'h0 | farApart(stopPos, teachStop[0]))
                      & (teachCount < 2'h2 | farApart(stopPos, teachStop[1]));
  wire        stopTake = stopEvt & (teachState == TEACH_RUN)
                         & (teachCount != 2'h3) & stopFar;

  always_comb
  begin
    rdData = 32'h0000_0000;
    rdOk = 1'b1;
    if (chHit)
      rdData = chIsCfg ? chCfg[chSel] : chPts[chSel];
    else
      case (req.index)
        `IDX_LOCKS:        rdData = {16'h0000, accessLocks};
        `IDX_PIN2:         rdData = {24'h00_0000, pin2Cfg};
        `IDX_POS_OFS:      rdData = {16'h0000, posOffset};
        `IDX_DET_RANGE:    rdData = detRange;
        `IDX_LAST_TRAVEL:  rdData = {16'h0000, lastTravel};
        `IDX_TOTAL_TRAVEL: rdData = totalTravel;
        `IDX_CYCLE_SUM:    rdData = cycleCount;
        `IDX_ALERTS:       rdData = {24'h00_0000, alertFlags};
        `IDX_OP_HOURS:     rdData = req.sub[1] ? opHoursSince : opHoursAll;
        `IDX_PWR_CYC:      rdData = req.sub[1] ? powerSince : powerAll;
        `IDX_TEMP:
          case (req.sub)
            8'h01:   rdData = {16'h0000, tempCur};
            8'h02:   rdData = {16'h0000, tempAllMax};
            8'h03:   rdData = {16'h0000, tempAllMin};
            8'h04:   rdData = {16'h0000, tempRstMax};
            8'h05:   rdData = {16'h0000, tempRstMin};
            default: rdOk = 1'b0;
          endcase
        default:           rdOk = 1'b0;
      endcase
  end

  // Settings fall back to defaults on either restore command
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      accessLocks <= 16'h0000;
      pin2Cfg <= `PIN2_QINT2;
      posOffset <= 16'h0000;
    end
    else if (restore)
    begin
      accessLocks <= 16'h0000;
      pin2Cfg <= `PIN2_QINT2;
      posOffset <= 16'h0000;
    end
    else
    begin
      if (wrLocks) accessLocks <= req.data[15:0];
      if (wrPin2) pin2Cfg <= code;
      if (wrOfs) posOffset <= req.data[15:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      detRange <= {`DET_HIGH, `DET_LOW};
    else
      detRange <= {`DET_HIGH + posOffset, `DET_LOW + posOffset};
  end

  assign mdcLow = detRange[15:0];
  assign mdcHigh = detRange[31:16];

  // Channel records survive restart; no spacing check here
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 8; i++)
      begin
        chPts[i] <= 32'h0000_0000;
        chCfg[i] <= `CFG_DEFAULT;
      end
      dynCh1 <= 1'b0;
    end
    else if (restore)
    begin
      for (int i = 0; i < 8; i++)
      begin
        chPts[i] <= 32'h0000_0000;
        chCfg[i] <= `CFG_DEFAULT;
      end
      dynCh1 <= 1'b0;
    end
    else if (cmdStore)
    begin
      chPts[0] <= {teachStop[1], teachStop[0]};
      chCfg[0][15:8] <= (teachCount == 2'h3) ? `MODE_GRIP
                                             : `MODE_MOVE;
      if (teachCount == 2'h3) chPts[1] <= {16'h0000, teachStop[2]};
      dynCh1 <= 1'b1;
    end
    else
    begin
      if (wrPts) chPts[chSel] <= req.data;
      if (wrCfg)
        chCfg[chSel] <= cfgMerge(chCfg[chSel], req.sub, req.data);
    end
  end

  // Totals keep counting through restart and restore
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      totalTravel <= 32'h0000_0000;
      cycleCount <= 32'h0000_0000;
      opHoursAll <= 32'h0000_0000;
      opHoursSince <= 32'h0000_0000;
      powerAll <= 32'h0000_0000;
      powerSince <= 32'h0000_0000;
    end
    else
    begin
      totalTravel <= ((cmdDiagReset | clrTravel) ? 32'h0000_0000 : totalTravel)
                     + (strokeEvt ? {16'h0000, strokeTravel} : 32'h0000_0000);
      cycleCount <= ((cmdDiagReset | clrCycles) ? 32'h0000_0000 : cycleCount)
                    + {31'h0000_0000, cycleEvt};
      opHoursAll <= opHoursAll + {31'h0000_0000, hourTick};
      opHoursSince <= (cmdDiagReset ? 32'h0000_0000 : opHoursSince)
                      + {31'h0000_0000, hourTick};
      powerAll <= powerAll + {31'h0000_0000, powerUpEvt};
      powerSince <= (cmdDiagReset ? 32'h0000_0000 : powerSince)
                    + {31'h0000_0000, powerUpEvt};
    end
  end

  // Volatile values are dropped by restart
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      lastTravel <= 16'h0000;
      accelPeak <= 16'h0000;
      tempCur <= 16'h0000;
      tempRstMax <= `TEMP_LOWEST;
      tempRstMin <= `TEMP_HIGHEST;
    end
    else if (cmdRestart)
    begin
      lastTravel <= 16'h0000;
      accelPeak <= 16'h0000;
      tempCur <= 16'h0000;
      tempRstMax <= `TEMP_LOWEST;
      tempRstMin <= `TEMP_HIGHEST;
    end
    else
    begin
      if (strokeEvt) lastTravel <= strokeTravel;
      tempCur <= tempNow;
      accelPeak <= (cmdDiagReset | accelNow > accelPeak) ? accelNow
                                                         : accelPeak;
      if (cmdDiagReset | tempClr)
      begin
        tempRstMax <= tempNow;
        tempRstMin <= tempNow;
      end
      else
      begin
        if ($signed(tempNow) > $signed(tempRstMax)) tempRstMax <= tempNow;
        if ($signed(tempNow) < $signed(tempRstMin)) tempRstMin <= tempNow;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tempAllMax <= `TEMP_LOWEST;
      tempAllMin <= `TEMP_HIGHEST;
    end
    else
    begin
      if ($signed(tempNow) > $signed(tempAllMax)) tempAllMax <= tempNow;
      if ($signed(tempNow) < $signed(tempAllMin)) tempAllMin <= tempNow;
    end
  end

  // A new alert in the clearing cycle stays set
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      alertFlags <= 8'h00;
    else
      alertFlags <= (cmdAlertClr ? 8'h00 : alertFlags) | alertIn;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      learnCount <= 2'h0;
    else if (restore || cmdRelearn)
      learnCount <= 2'h0;
    else if (strokeEvt && learnCount != `LEARN_STROKES)
      learnCount <= learnCount + 2'h1;
  end

  assign learned = (learnCount == `LEARN_STROKES);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      teachState <= TEACH_IDLE;
      teachCount <= 2'h0;
    end
    else if (restore || cmdRestart)
    begin
      teachState <= TEACH_IDLE;
      teachCount <= 2'h0;
    end
    else
    begin
      case (teachState)
        TEACH_IDLE: if (cmdStart) teachState <= TEACH_RUN;
        TEACH_RUN:  if (cmdStop) teachState <= TEACH_DONE;
        TEACH_DONE:
          if (cmdStart) teachState <= TEACH_RUN;
          else if (cmdStore) teachState <= TEACH_IDLE;
        default:    teachState <= TEACH_IDLE;
      endcase
      if (cmdStart)
        teachCount <= 2'h0;
      else if (stopTake)
        teachCount <= nextTeachCount;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (stopTake) teachStop[teachCount] <= stopPos;
  end

  // Two stages before the edge detector; the pin is asynchronous
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      btnMeta <= 1'b0;
      btnSync <= 1'b0;
      btnLast <= 1'b0;
      teachPress <= 1'b0;
    end
    else
    begin
      btnMeta <= teachButtonPin;
      btnSync <= btnMeta;
      btnLast <= btnSync;
      teachPress <= btnSync & ~btnLast
                    & ~accessLocks[`LOCK_UI_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rspValid <= 1'b0;
      rsp <= '0;
      procData <= '0;
      pin2Out <= 1'b0;
      pin2Oe <= 1'b0;
      identReset <= 1'b0;
      deviceRestart <= 1'b0;
    end
    else
    begin
      rspValid <= reqValid;
      rsp.error <= reqValid & (isWr ? ~wrOk : ~rdOk);
      rsp.data <= isRd ? rdData : 32'h0000_0000;
      procData <= {posSum, `PD_SCALE, swIn};
      pin2Oe <= (pin2Cfg == `PIN2_QINT2);
      pin2Out <= (pin2Cfg == `PIN2_QINT2) & swIn[1];
      identReset <= cmdFactory;
      deviceRestart <= cmdRestart;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_startStop;
    (teachState == TEACH_RUN) ##0 cmdStop;
  endsequence

  property p_restartKeeps;
    cmdRestart & ~strokeEvt & ~cycleEvt |=> $stable(totalTravel)
      && $stable(cycleCount);
  endproperty
  a_restartKeeps: assert property (p_restartKeeps)
    else $error("restart changed a retained total");
  property p_volatileDrop;
    cmdRestart |=> lastTravel == 16'h0000 && accelPeak == 16'h0000;
  endproperty
  a_volatileDrop: assert property (p_volatileDrop)
    else $error("restart kept a volatile value");
  property p_recordsHeld;
    cmdRestart |=> $stable(chCfg[0]) && $stable(chPts[0]);
  endproperty
  a_recordsHeld: assert property (p_recordsHeld)
    else $error("restart lost a channel record");
  property p_restoreKeeps;
    cmdFactory & ~cycleEvt & ~hourTick |=> posOffset == 16'h0000
      && $stable(cycleCount) && $stable(opHoursAll);
  endproperty
  a_restoreKeeps: assert property (p_restoreKeeps)
    else $error("factory restore wrong on settings or counters");
  property p_diagReset;
    cmdDiagReset & ~cycleEvt & ~strokeEvt |=> cycleCount == 32'h0000_0000
      && totalTravel == 32'h0000_0000;
  endproperty
  a_diagReset: assert property (p_diagReset)
    else $error("diagnostic reset left a counter");
  property p_alertClear;
    cmdAlertClr & (alertIn == 8'h00) |=> alertFlags == 8'h00;
  endproperty
  a_alertClear: assert property (p_alertClear)
    else $error("alerts not cleared");
  property p_travelClr;
    clrTravel & ~strokeEvt |=> totalTravel == 32'h0000_0000
      && !rsp.error;
  endproperty
  a_travelClr: assert property (p_travelClr)
    else $error("travel clear failed");
  property p_teachFlow;
    s_startStop |=> teachState == TEACH_DONE;
  endproperty
  a_teachFlow: assert property (p_teachFlow)
    else $error("teach start then stop did not finish");
  property p_buttonLock;
    accessLocks[`LOCK_UI_BIT] |=> !teachPress;
  endproperty
  a_buttonLock: assert property (p_buttonLock)
    else $error("button press passed through the lock");
  property p_badCmd;
    cmdTaken & ~cmdOk |=> rspValid && rsp.error;
  endproperty
  a_badCmd: assert property (p_badCmd)
    else $error("bad command not refused");
  property p_posOut;
    reqValid | ~reqValid |=> procData.pos == $past(posSum);
  endproperty
  a_posOut: assert property (p_posOut)
    else $error("position output lacks offset");
  property p_ptsGuard;
    isWr & chHit & ~chIsCfg & ~modeManual2 |=> rsp.error ##0
      $stable(chPts[0]);
  endproperty
  a_ptsGuard: assert property (p_ptsGuard)
    else $error("points written in a wrong mode");
endmodule
`default_nettype wire

/* tb/param_master.sv */
// Parameter master model: one request at a time
`timescale 1ns/1ps
`default_nettype none
module param_master (
  input  wire logic                   clk_sys,
  output var  logic                   reqValid,
  output var  sensor_param_pkg::req_t req,
  input  wire logic                   rspValid,
  input  wire sensor_param_pkg::rsp_t rsp
);
  initial
  begin
    reqValid = 1'h0;
    req      = '0;
  end
  // Fields are scrambled after release so a stale request cannot pass
  task automatic xfer(input logic w, input logic [15:0] i,
                      input logic [7:0] s, input logic [31:0] d,
                      output sensor_param_pkg::rsp_t r);
    @(posedge clk_sys);
    reqValid <= 1'h1;
    req      <= {w, i, s, d};
    @(posedge clk_sys);
    reqValid <= 1'h0;
    req      <= ~{w, i, s, d};
    @(posedge clk_sys);
    r = rsp;
    if (rspValid !== 1'h1)
      r.error = 1'hx;
  endtask
endmodule
`default_nettype wire

/* tb/sensor_param_command_handler_test.sv */
// Self-checking bench of the parameter and command handler
`timescale 1ns/1ps
`default_nettype none
module sensor_param_command_handler_test;
  typedef struct packed {
    logic        w;
    logic [15:0] i;
    logic [31:0] v;
    logic        e;
  } row_t;
  logic        clk_sys, rst, reqValid, rspValid, strokeEvt, cycleEvt;
  logic        stopEvt, hourTick, powerUpEvt, teachButtonPin, teachPress;
  logic        pin2Out, pin2Oe, learned, identReset, deviceRestart;
  logic [15:0] measPos, strokeTravel, stopPos, tempNow, accelNow;
  logic [15:0] mdcLow, mdcHigh;
  logic [7:0]  alertIn, swIn;
  int          badCount, testsRun, cyc, pressCnt, identCnt, n;
  int          restartCnt;
  logic [15:0] stops [3] = '{16'h0064, 16'h0096, 16'h012C};
  sensor_param_pkg::req_t req;
  sensor_param_pkg::rsp_t rsp, rs;
  sensor_param_pkg::pd_t  procData;
  row_t        rows [15] = '{
    '{1'h1, 16'h0101, 32'h10, 1'h0}, '{1'h0, 16'h0101, 32'h10, 1'h0},
    '{1'h0, 16'h0079, 32'h1, 1'h0}, '{1'h1, 16'h0002, 32'h55, 1'h1},
    '{1'h1, 16'h0002, 32'h4D, 1'h1}, '{1'h0, 16'h0002, 32'h0, 1'h1},
    '{1'h1, 16'h112E, 32'h3, 1'h1}, '{1'h1, 16'h003C, 32'h50004, 1'h1},
    '{1'h1, 16'h003D, 32'h460200, 1'h0}, '{1'h1, 16'h003C, 32'h50004, 1'h0},
    '{1'h0, 16'h003C, 32'h50004, 1'h0}, '{1'h0, 16'h003F, 32'h460400, 1'h0},
    '{1'h1, 16'h4000, 32'h1, 1'h1}, '{1'h0, 16'h400B, 32'h460400, 1'h0},
    '{1'h1, 16'h0104, 32'h0, 1'h1}};

  sensor_param_command_handler u_dut (.clk_sys, .rst, .reqValid, .req,
    .rspValid, .rsp, .measPos, .strokeEvt, .strokeTravel, .cycleEvt,
    .stopEvt, .stopPos, .hourTick, .powerUpEvt, .tempNow, .accelNow,
    .alertIn, .swIn, .teachButtonPin, .teachPress, .pin2Out, .pin2Oe,
    .procData, .mdcLow, .mdcHigh, .learned, .identReset, .deviceRestart);
  param_master u_master (.clk_sys, .reqValid, .req, .rspValid, .rsp);

  task automatic chk(input string nm, input logic [31:0] e, g);
    testsRun++;
    if (g !== e)
    begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rq(input logic w, input logic [15:0] i,
                    input logic [7:0] s, input logic [31:0] v);
    u_master.xfer(w, i, s, v, rs);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] s,
                    input logic [31:0] e);
    rq(1'h0, i, s, 32'h0);
    chk("read error", 32'h0, {31'h0, rs.error});
    chk("read data", e, rs.data);
  endtask
  task automatic cmd(input logic [7:0] c);
    rq(1'h1, 16'h0002, 8'h00, {24'h0, c});
    chk("command error", 32'h0, {31'h0, rs.error});
  endtask
  // Bits: cycle, stroke, stop, alert 0
  task automatic pulses(input logic [3:0] m);
    @(posedge clk_sys);
    {cycleEvt, strokeEvt, stopEvt, alertIn[0]} <= m;
    @(posedge clk_sys);
    {cycleEvt, strokeEvt, stopEvt, alertIn[0]} <= 4'h0;
  endtask
  // Held well past the two-stage synchroniser
  task automatic press();
    @(posedge clk_sys);
    teachButtonPin <= 1'h1;
    repeat (3) @(posedge clk_sys);
    teachButtonPin <= 1'h0;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Whole run needs about 200 cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    pressCnt += int'(teachPress === 1'h1);
    identCnt += int'(identReset === 1'h1);
    restartCnt += int'(deviceRestart === 1'h1);
    if (cyc == 3000)
    begin
      badCount++;
      report_and_stop();
    end
  end

  initial
  begin
    {rst, strokeEvt, cycleEvt, stopEvt, hourTick, powerUpEvt} = 6'h20;
    teachButtonPin = 1'h0;
    {measPos, strokeTravel, stopPos, tempNow, accelNow} = '0;
    {alertIn, swIn} = '0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    chk("mdc low", 32'hF63C, {16'h0, mdcLow});
    chk("mdc high", 32'h09C4, {16'h0, mdcHigh});
    measPos <= 16'h0100;
    swIn <= 8'hA5;
    foreach (rows[k])
    begin
      rq(rows[k].w, rows[k].i, 8'h00, rows[k].v);
      chk("error", {31'h0, rows[k].e}, {31'h0, rs.error});
      if (!rows[k].e)
        chk("data", rows[k].w ? 32'h0 : rows[k].v, rs.data);
    end
    chk("process data", 32'h0110FEA5, procData);
    chk("mdc low", 32'hF64C, {16'h0, mdcLow});
    chk("mdc high", 32'h09D4, {16'h0, mdcHigh});
    $display("test table finished");
    repeat (3) pulses(4'h8);
    strokeTravel <= 16'h0123;
    pulses(4'h4);
    tempNow <= 16'h0019;
    rd(16'h111E, 8'h00, 32'h3);
    rd(16'h1114, 8'h00, 32'h123);
    n = restartCnt;
    cmd(8'h80);
    rd(16'h1114, 8'h00, 32'h0);
    chk("restarts", 32'h1, 32'(restartCnt - n));
    rd(16'h111E, 8'h00, 32'h3);
    rq(1'h1, 16'h112E, 8'h00, 32'h2);
    rd(16'h111E, 8'h00, 32'h0);
    pulses(4'h8);
    cmd(8'hE4);
    rd(16'h111E, 8'h00, 32'h0);
    rq(1'h1, 16'h1101, 8'h00, 32'h0);
    rd(16'h1100, 8'h04, 32'h19);
    pulses(4'h1);
    rd(16'h1130, 8'h00, 32'h1);
    cmd(8'hE5);
    rd(16'h1130, 8'h00, 32'h0);
    $display("test counters finished");
    cmd(8'h4B);
    foreach (stops[k])
    begin
      stopPos <= stops[k];
      pulses(4'h2);
    end
    cmd(8'h4C);
    cmd(8'h4D);
    rd(16'h003C, 8'h00, 32'h012C0064);
    rq(1'h0, 16'h003D, 8'h00, 32'h0);
    chk("taught mode", 32'h82, {24'h0, rs.data[15:8]});
    rq(1'h1, 16'h003D, 8'h02, 32'h0300);
    chk("mode refused", 32'h1, {31'h0, rs.error});
    $display("test teach finished");
    rq(1'h1, 16'h0079, 8'h00, 32'h0);
    @(posedge clk_sys);
    chk("pin2 enable", 32'h0, {31'h0, pin2Oe});
    swIn <= 8'h5A;
    rq(1'h1, 16'h0079, 8'h00, 32'h1);
    @(posedge clk_sys);
    chk("pin2 enable", 32'h1, {31'h0, pin2Oe});
    chk("pin2 out", 32'h1, {31'h0, pin2Out});
    rq(1'h1, 16'h000C, 8'h00, 32'h8);
    n = pressCnt;
    press();
    chk("locked presses", 32'h0, 32'(pressCnt - n));
    rq(1'h1, 16'h000C, 8'h00, 32'h0);
    n = pressCnt;
    press();
    chk("presses", 32'h1, 32'(pressCnt - n));
    $display("test pins finished");
    pulses(4'h8);
    n = identCnt;
    cmd(8'h82);
    rd(16'h0101, 8'h00, 32'h0);
    rd(16'h111E, 8'h00, 32'h1);
    chk("identity resets", 32'h1, 32'(identCnt - n));
    rq(1'h1, 16'h0101, 8'h00, 32'h10);
    n = identCnt;
    cmd(8'h81);
    rd(16'h0101, 8'h00, 32'h0);
    chk("identity resets", 32'h0, 32'(identCnt - n));
    cmd(8'hC0);
    pulses(4'h4);
    chk("learned", 32'h0, {31'h0, learned});
    pulses(4'h4);
    @(posedge clk_sys);
    chk("learned", 32'h1, {31'h0, learned});
    $display("test restore finished");
    report_and_stop();
  end
endmodule
`default_nettype wire
